// File: common/dsi_pkg.sv
// Constants, types and register layout of the drive safety interlock
//------------------------------------------------------------------------------
// Operation
// RQ1: Watchdog silence drops drive power, drive brakes and dome drive devices.
// RQ2: Watchdog disables dome devices only while dome keyswitch selects computer.
// RQ3: Momentary keyoff, watchdog, estop or stop removes all brake and drive power.
// RQ4: After such a trip, power stays off until a keyswitch start pulse.
// RQ5: Estop switch disables drives, brakes, dome and estop auxiliary outputs; flagged.
// RQ6: Computer stop command sets a latch acting like estop; latch is reported.
// RQ7: Operator clears a stop: key off, safe drives, reset command, key on, start.
// RQ8: Keyswitch off disables drives, brakes and dome devices; position reported.
// RQ9: Lockout disables main power, main amplifiers and main brakes; flagged.
// RQ10: Either azimuth hard limit disables main drive; each limit flagged.
// RQ11: Either elevation hard limit disables main drive; each limit flagged.
// RQ12: Either axis overspeed disables main drive; each overspeed flagged.
// RQ13: Overspeed and computer stop latch on momentary condition until reset.
// RQ14: Held override bypasses hard limits and resets overspeed and stop latches.
// RQ15: Override leaves keyoff, watchdog, estop, lockout and latch pin untouched.
// RQ16: Software never commands motion toward an active hard limit.
// RQ17: Keyswitch start pulse clears overspeed without turning the key off.
// RQ18: Engaged elevation latch pin disables only elevation amplifiers; flagged.
// RQ19: Operator leaves a limit under override, one axis, then releases override.
// RQ20: Software makes drives safe before re-arming via the keyswitch sequence.
// RQ21: All pins are synchronised and debounced; start is one rising-edge event.
// RQ22: After reset all power, amplifier, brake and dome outputs stay disabled.
//------------------------------------------------------------------------------
package dsi_pkg;

    // Register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS    = 8'h04;
    localparam int          CTRL_STOP_BIT = 0;
    localparam int          CTRL_KICK_BIT = 1;

    // Timing
    localparam int          CLK_MHZ       = 100;
    localparam int          DEB_NS        = 5000;
    localparam int          DEB_CYC       = (DEB_NS * CLK_MHZ + 999) / 1000;
    localparam int          DEB_W         = 10;
    localparam int          WD_TIMEOUT_MS = 100;
    localparam int          WD_CYC_DEF    = WD_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int          WD_W          = 24;

    // Switch and sensor pins, high while the condition is present
    typedef struct packed {
        logic key_on;
        logic key_start;
        logic estop_switch;
        logic lockout;
        logic az_clockwise_hard_limit;
        logic az_counterclockwise_hard_limit;
        logic el_up_hard_limit;
        logic el_down_hard_limit;
        logic az_overspeed;
        logic el_overspeed;
        logic el_latch_pin;
        logic override_held;
        logic dome_computer;
    } dsi_sw_t;

    localparam int          NSW           = $bits(dsi_sw_t);

    // Drive enables, high means energised or released
    typedef struct packed {
        logic main_pwr;
        logic rot_pwr;
        logic main_brake_rel;
        logic rot_brake_rel;
        logic az_amp;
        logic el_amp;
        logic dome_brake;
        logic dome_clamp;
        logic dome_inv;
        logic dome_inv_relay;
        logic estop_aux;
        logic estop_opto;
    } dsi_drv_t;

    // Status word, low bits of the status register
    typedef struct packed {
        logic dome_trip;
        logic drive_trip;
        logic wd_alive;
        logic stop_latch;
        logic el_overspeed;
        logic az_overspeed;
        dsi_sw_t sw;
    } dsi_status_t;

endpackage : dsi_pkg

// File: src/dsi_interlock.sv
// Drive safety interlock: pin conditioning, trip latches, output gating, registers
`timescale 1ns/1ps
module dsi_interlock
    import dsi_pkg::*;
#(
    parameter int unsigned WD_CYC = WD_CYC_DEF
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // Switch and sensor pins
    input  wire dsi_sw_t           sw_pins,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    // Power, amplifier, brake and dome enables
    output dsi_drv_t               drv_en
);

    //--------------------------------------------------------------------------
    // Pin conditioning
    //--------------------------------------------------------------------------
    logic [NSW-1:0]   sync1_r;
    logic [NSW-1:0]   sync2_r;
    logic [NSW-1:0]   deb_r;
    logic [DEB_W-1:0] deb_cnt_r [NSW];
    dsi_sw_t          sw;
    logic             start_d_r;
    logic             start_ev;

    // Two-stage synchroniser on every pin
    always_ff @(posedge clk_sys) begin // RQ21
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sw_pins;
            sync2_r <= sync1_r;
        end
    end

    // Debounce: a new level must hold for the whole debounce time
    genvar gi;
    generate
        for (gi = 0; gi < NSW; gi++) begin : g_deb
            wire logic differs = sync2_r[gi] != deb_r[gi];
            wire logic settled = deb_cnt_r[gi] == DEB_W'(DEB_CYC - 1);
            always_ff @(posedge clk_sys) begin // RQ21
                if (!resetn) begin
                    deb_r[gi]     <= 1'b0;
                    deb_cnt_r[gi] <= '0;
                end else if (!differs) begin
                    deb_cnt_r[gi] <= '0;
                end else if (settled) begin
                    deb_r[gi]     <= sync2_r[gi];
                    deb_cnt_r[gi] <= '0;
                end else begin
                    deb_cnt_r[gi] <= deb_cnt_r[gi] + DEB_W'(1);
                end
            end
        end
    endgenerate

    assign sw = dsi_sw_t'(deb_r);

    // Start position as a single rising-edge event
    // The key must leave start before another event can follow
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            start_d_r <= 1'b0;
        end else begin
            start_d_r <= sw.key_start;
        end
    end

    assign start_ev = sw.key_start && !start_d_r; // RQ21

    //--------------------------------------------------------------------------
    // Register decode
    //--------------------------------------------------------------------------
    logic        stop_cmd_r;
    logic [WD_W-1:0] wd_cnt_r;
    logic        ctrl_wr;
    logic        kick;
    logic        wd_alive;

    assign ctrl_wr  = reg_wr && (reg_addr == CTRL_OFS);
    assign kick     = ctrl_wr && reg_wdata[CTRL_KICK_BIT];
    assign wd_alive = wd_cnt_r != '0;

    // Stop command level held by the control computer
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stop_cmd_r <= 1'b0;
        end else if (ctrl_wr) begin
            stop_cmd_r <= reg_wdata[CTRL_STOP_BIT];
        end
    end

    // Watchdog: each kick reloads, silence runs it down to dead
    // Dead after reset, so no main or rotator drive can start before the first kick
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wd_cnt_r <= '0;
        end else if (kick) begin
            wd_cnt_r <= WD_W'(WD_CYC);
        end else if (wd_alive) begin
            wd_cnt_r <= wd_cnt_r - WD_W'(1);
        end
    end

    //--------------------------------------------------------------------------
    // Trip latches
    //--------------------------------------------------------------------------
    logic stop_latch_r;
    logic az_ovsp_r;
    logic el_ovsp_r;
    logic drive_trip_r;
    logic dome_trip_r;
    logic live_now;
    logic dome_live;
    logic total_now;
    logic dome_now;
    logic stop_clr;
    logic rearm_ok;
    logic dome_rearm;

    // Conditions present at the pins or the watchdog right now
    assign live_now   = !sw.key_on || !wd_alive || sw.estop_switch; // RQ15
    // Watchdog only reaches the dome in computer position
    assign dome_live  = !sw.key_on || sw.estop_switch
                      || (!wd_alive && sw.dome_computer); // RQ2
    // Conditions that kill every drive power, drive brake and amplifier output
    assign total_now  = live_now || stop_latch_r; // RQ3
    assign dome_now   = dome_live || stop_latch_r;
    // A start that clears the stop latch also rearms in the same cycle, so one
    // start pulse is enough once the stop command has been withdrawn
    assign stop_clr   = start_ev && !stop_cmd_r; // RQ7
    assign rearm_ok   = stop_clr && !live_now; // RQ4
    assign dome_rearm = stop_clr && !dome_live; // RQ4

    // Stop latch: set wins; cleared by start once command is gone, or override
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stop_latch_r <= 1'b0;
        end else if (stop_cmd_r) begin
            stop_latch_r <= 1'b1; // RQ6 RQ13
        end else if (start_ev || sw.override_held) begin
            stop_latch_r <= 1'b0; // RQ7 RQ14
        end
    end

    // Overspeed latches: set wins; start or override clears
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            az_ovsp_r <= 1'b0;
            el_ovsp_r <= 1'b0;
        end else begin
            az_ovsp_r <= sw.az_overspeed
                      || (az_ovsp_r && !start_ev && !sw.override_held); // RQ13 RQ14 RQ17
            el_ovsp_r <= sw.el_overspeed
                      || (el_ovsp_r && !start_ev && !sw.override_held); // RQ13 RQ14 RQ17
        end
    end

    // Momentary trips hold power off until a start pulse; tripped at reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            drive_trip_r <= 1'b1; // RQ22
            dome_trip_r  <= 1'b1;
        end else begin
            drive_trip_r <= (total_now || drive_trip_r) && !rearm_ok; // RQ3 RQ4
            dome_trip_r  <= (dome_now || dome_trip_r) && !dome_rearm; // RQ4
        end
    end

    //--------------------------------------------------------------------------
    // Output gating
    //--------------------------------------------------------------------------
    logic     drive_ok;
    logic     dome_ok;
    logic     limit_hit;
    logic     main_ilk;
    logic     estop_ok;
    dsi_drv_t drv_nxt;

    assign drive_ok  = !drive_trip_r && !total_now; // RQ1 RQ8
    assign dome_ok   = !dome_trip_r && !dome_now;
    assign limit_hit = sw.az_clockwise_hard_limit || sw.az_counterclockwise_hard_limit
                     || sw.el_up_hard_limit || sw.el_down_hard_limit; // RQ10 RQ11
    // Override bypasses limits and overspeed only, never lockout
    assign main_ilk  = sw.lockout
                     || (!sw.override_held && (limit_hit || az_ovsp_r || el_ovsp_r)); // RQ9 RQ12 RQ14
    assign estop_ok  = !sw.estop_switch && !stop_latch_r; // RQ5 RQ6

    assign drv_nxt.main_pwr       = drive_ok && !main_ilk;
    assign drv_nxt.rot_pwr        = drive_ok;
    assign drv_nxt.main_brake_rel = drive_ok && !main_ilk;
    assign drv_nxt.rot_brake_rel  = drive_ok;
    assign drv_nxt.az_amp         = drive_ok && !main_ilk;
    assign drv_nxt.el_amp         = drive_ok && !main_ilk && !sw.el_latch_pin; // RQ18
    assign drv_nxt.dome_brake     = dome_ok;
    assign drv_nxt.dome_clamp     = dome_ok;
    assign drv_nxt.dome_inv       = dome_ok;
    assign drv_nxt.dome_inv_relay = dome_ok;
    assign drv_nxt.estop_aux      = estop_ok;
    assign drv_nxt.estop_opto     = estop_ok;

    // Registered enables, all off under reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            drv_en <= '0; // RQ22
        end else begin
            drv_en <= drv_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Register read
    //--------------------------------------------------------------------------
    dsi_status_t       status;
    logic [DATA_W-1:0] rdata_nxt;

    assign status.dome_trip    = dome_trip_r;
    assign status.drive_trip   = drive_trip_r;
    assign status.wd_alive     = wd_alive;
    assign status.stop_latch   = stop_latch_r; // RQ6
    assign status.el_overspeed = el_ovsp_r; // RQ12
    assign status.az_overspeed = az_ovsp_r; // RQ12
    assign status.sw           = sw; // RQ5 RQ8 RQ9 RQ10 RQ11 RQ18

    assign rdata_nxt = !reg_rd                   ? '0 :
                       (reg_addr == CTRL_OFS)   ? DATA_W'(stop_cmd_r) :
                       (reg_addr == STATUS_OFS) ? DATA_W'(status) : '0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    wd_drop_a: assert property ( // RQ1
        !wd_alive |=> !drv_en.main_pwr && !drv_en.rot_pwr && !drv_en.rot_brake_rel)
        else $error("watchdog dead but drive enabled");

    dome_wd_a: assert property ( // RQ2
        (!wd_alive && sw.dome_computer) |=> !drv_en.dome_inv && !drv_en.dome_inv_relay)
        else $error("watchdog dead but dome enabled in computer mode");

    trip_hold_a: assert property ( // RQ4
        (drive_trip_r && !start_ev) |=> drive_trip_r ##1 !drv_en.rot_pwr)
        else $error("drive trip released without start pulse");

    estop_off_a: assert property ( // RQ5
        sw.estop_switch |=> !drv_en.estop_aux && !drv_en.dome_clamp && !drv_en.main_brake_rel)
        else $error("estop switch but outputs enabled");

    stop_latch_a: assert property ( // RQ6
        stop_cmd_r |=> stop_latch_r ##1 !drv_en.estop_opto)
        else $error("stop command not latched");

    key_off_a: assert property ( // RQ8
        !sw.key_on |=> !drv_en.rot_brake_rel && !drv_en.dome_brake)
        else $error("key off but brakes released");

    lockout_a: assert property ( // RQ9
        sw.lockout |=> !drv_en.main_pwr && !drv_en.az_amp)
        else $error("lockout but main drive enabled");

    limit_a: assert property ( // RQ10
        (limit_hit && !sw.override_held) |=> !drv_en.main_brake_rel && !drv_en.el_amp)
        else $error("hard limit but main drive enabled");

    ovsp_hold_a: assert property ( // RQ13
        (az_ovsp_r && !start_ev && !sw.override_held) |=> az_ovsp_r)
        else $error("overspeed latch lost");

    ovsp_clear_a: assert property ( // RQ17
        (el_ovsp_r && start_ev && !sw.el_overspeed) |=> !el_ovsp_r)
        else $error("start pulse did not clear overspeed");

    latch_pin_a: assert property ( // RQ18
        sw.el_latch_pin |=> !drv_en.el_amp)
        else $error("latch pin engaged but elevation amp on");

    start_once_a: assert property ( // RQ21
        start_ev |=> !start_ev)
        else $error("start event longer than one cycle");

    elev_limit_a: assert property ( // RQ11
        ((sw.el_up_hard_limit || sw.el_down_hard_limit) && !sw.override_held) |=> !drv_en.main_pwr)
        else $error("elevation limit but main drive enabled");

    ovsp_off_a: assert property ( // RQ12
        ((az_ovsp_r || el_ovsp_r) && !sw.override_held) |=> !drv_en.main_pwr && !drv_en.main_brake_rel)
        else $error("overspeed latched but main drive enabled");

    ovsp_set_a: assert property ( // RQ13
        (sw.az_overspeed || sw.el_overspeed) |=> az_ovsp_r || el_ovsp_r)
        else $error("overspeed trip not latched");

    ovr_bypass_a: assert property ( // RQ14
        (sw.override_held && !sw.lockout && !sw.el_latch_pin && drive_ok) |=> drv_en.main_pwr && drv_en.el_amp)
        else $error("override held but main drive still blocked");

    ovr_keep_a: assert property ( // RQ15
        (sw.override_held && (sw.lockout || sw.el_latch_pin || !sw.key_on)) |=> !drv_en.el_amp)
        else $error("override bypassed a fixed interlock");

    all_off_a: assert property ( // RQ3
        total_now |=> !drv_en.main_pwr && !drv_en.rot_pwr && !drv_en.main_brake_rel && !drv_en.rot_brake_rel)
        else $error("trip present but drive or brake enabled");

    maint_dome_a: assert property ( // RQ2
        (!wd_alive && !sw.dome_computer && !dome_trip_r && sw.key_on && !sw.estop_switch && !stop_latch_r)
        |=> drv_en.dome_inv && drv_en.dome_brake)
        else $error("watchdog reached the dome in maintenance position");

    wd_kick_a: assert property ( // RQ1
        kick |=> wd_alive)
        else $error("watchdog kick did not revive it");

    deb_hold_a: assert property ( // RQ21
        (sync2_r == deb_r) |=> $stable(deb_r))
        else $error("debounced pin moved without a pin change");

    rearm_c: cover property (drive_trip_r ##1 !drive_trip_r ##1 drv_en.main_pwr);
    maint_c: cover property (!wd_alive && !sw.dome_computer && drv_en.dome_inv);
    ovr_c:   cover property (limit_hit && sw.override_held ##1 drv_en.az_amp);
    stop_c:  cover property (stop_cmd_r ##1 stop_latch_r ##1 !stop_cmd_r);
    ovsp_c:  cover property (az_ovsp_r && start_ev ##1 !az_ovsp_r);

endmodule : dsi_interlock

// File: test/dsi_panel.sv
// Switch panel model: operator switches and sensors whose contacts bounce
`timescale 1ns/1ps
module dsi_panel
    import dsi_pkg::*;
#(
    parameter int BOUNCE = 40
) (
    // Clock
    input  wire logic    clk_sys,
    // Positions chosen by the operator
    input  wire dsi_sw_t want,
    // Contacts as the block sees them
    output dsi_sw_t      sw_pins
);
    //--------------------------------------------------------------------------
    // Contact bounce
    //--------------------------------------------------------------------------
    dsi_sw_t old_r = '0;
    dsi_sw_t tgt_r = '0;
    int      cnt_r = 0;
    initial sw_pins = '0;
    // A moved contact chatters between old and new position before it rests
    always @(posedge clk_sys) begin
        if (want !== tgt_r) begin
            old_r <= sw_pins;
            tgt_r <= want;
            cnt_r <= BOUNCE;
        end else if (cnt_r > 0) begin
            cnt_r   <= cnt_r - 1;
            sw_pins <= (cnt_r % 7 < 3) ? old_r : tgt_r;
        end else begin
            sw_pins <= tgt_r;
        end
    end
endmodule : dsi_panel

// File: test/test_drive_safety_interlock.sv
// Self-checking bench of the drive safety interlock
`timescale 1ns/1ps
module test_drive_safety_interlock;
    import dsi_pkg::*;
    //--------------------------------------------------------------------------
    // Settings and signals
    //--------------------------------------------------------------------------
    localparam int          WD       = 3000;    // Shortened watchdog timeout
    localparam int          SETTLE   = 600;     // Bounce, debounce and output flop
    localparam logic [11:0] ALL_ON   = 12'hfff;
    localparam logic [11:0] MAIN_OFF = 12'h53f; // Main power, main brakes, amps off
    localparam logic [11:0] DRIVES   = 12'hf3c; // Drive power, drive brakes, dome
    localparam logic [11:0] DOME     = 12'h03c;
    logic              clk_sys   = 1'b0;
    logic              resetn    = 1'b0;
    dsi_sw_t           want      = '0;
    dsi_sw_t           sw_pins;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    dsi_drv_t          drv_en;
    logic              stop_cmd  = 1'b0;
    int                fail_count = 0;
    int                checks     = 0;

    always #5 clk_sys = ~clk_sys;

    dsi_interlock #(.WD_CYC(WD)) dut (.clk_sys(clk_sys), .resetn(resetn), .sw_pins(sw_pins),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .drv_en(drv_en));
    dsi_panel panel (.clk_sys(clk_sys), .want(want), .sw_pins(sw_pins));

    //--------------------------------------------------------------------------
    // Bus, timing and compare tasks
    //--------------------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic chk_reg(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                           input logic [DATA_W-1:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        checks++;
        if ((reg_rdata & m) !== (e & m)) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, e & m, reg_rdata & m);
        end
    endtask : chk_reg

    task automatic chk_drv(input string what, input logic [11:0] m, input logic [11:0] e);
        checks++;
        if ((drv_en & m) !== (e & m)) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, e & m, drv_en & m);
        end
    endtask : chk_drv

    // Kick the watchdog, keeping the stop command, then let the pins settle
    task automatic settle();
        wr(CTRL_OFS, {30'h0000_0000, 1'b1, stop_cmd});
        repeat (SETTLE) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic start_pulse();
        want.key_start <= 1'b1;
        settle();
        want.key_start <= 1'b0;
        settle();
    endtask : start_pulse

    //--------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------
    task automatic t_power_up();
        want.key_on        <= 1'b1;
        want.dome_computer <= 1'b1;
        settle();
        chk_drv("enables before start", ALL_ON, 12'h003);
        chk_reg("status", STATUS_OFS, 32'h0001_1001, 32'h0001_1001);
        chk_reg("control", CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
        chk_reg("unmapped", 8'h08, 32'hffff_ffff, 32'h0000_0000);
        start_pulse();
        chk_drv("enables after start", ALL_ON, ALL_ON);
        want.estop_switch <= 1'b1;
        repeat (100) @(posedge clk_sys);
        want.estop_switch <= 1'b0;
        settle();
        chk_drv("short glitch", ALL_ON, ALL_ON);
        $display("Test power_up done");
    endtask : t_power_up

    task automatic t_estop();
        want.estop_switch <= 1'b1;
        settle();
        chk_drv("estop", ALL_ON, 12'h000);
        chk_reg("estop flag", STATUS_OFS, 32'h0000_0400, 32'h0000_0400);
        want.estop_switch <= 1'b0;
        settle();
        chk_drv("estop released", ALL_ON, 12'h003);
        start_pulse();
        chk_drv("estop recovered", ALL_ON, ALL_ON);
        $display("Test estop done");
    endtask : t_estop

    task automatic t_stop();
        stop_cmd = 1'b1;
        wr(CTRL_OFS, 32'h0000_0001);
        stop_cmd = 1'b0;
        settle();
        chk_drv("momentary stop", ALL_ON, 12'h000);
        chk_reg("stop latch", STATUS_OFS, 32'h0000_8000, 32'h0000_8000);
        want.key_on <= 1'b0;
        settle();
        chk_drv("key off", DRIVES, 12'h000);
        chk_reg("key flag", STATUS_OFS, 32'h0000_1000, 32'h0000_0000);
        want.key_on <= 1'b1;
        settle();
        chk_drv("key on no start", ALL_ON, 12'h000);
        start_pulse();
        chk_drv("stop recovered", ALL_ON, ALL_ON);
        stop_cmd = 1'b1;
        settle();
        stop_cmd = 1'b0;
        want.override_held <= 1'b1;
        settle();
        chk_reg("stop overridden", STATUS_OFS, 32'h0000_8000, 32'h0000_0000);
        chk_drv("overridden no start", ALL_ON, 12'h003);
        want.override_held <= 1'b0;
        settle();
        start_pulse();
        chk_drv("override recovered", ALL_ON, ALL_ON);
        $display("Test stop done");
    endtask : t_stop

    task automatic t_watchdog();
        want.dome_computer <= 1'b0;
        settle();
        repeat (WD + 50) @(posedge clk_sys);
        chk_drv("watchdog maintenance", DRIVES, DOME);
        chk_reg("watchdog flag", STATUS_OFS, 32'h0001_0000, 32'h0000_0000);
        want.dome_computer <= 1'b1;
        settle();
        start_pulse();
        repeat (WD + 50) @(posedge clk_sys);
        chk_drv("watchdog computer", DRIVES, 12'h000);
        settle();
        chk_drv("kicked no start", DRIVES, 12'h000);
        start_pulse();
        chk_drv("watchdog recovered", ALL_ON, ALL_ON);
        $display("Test watchdog done");
    endtask : t_watchdog

    // Lockout, four hard limits and two overspeed trips
    task automatic t_main();
        int bits [7] = '{9, 8, 7, 6, 5, 4, 3};
        int b;
        foreach (bits[i]) begin
            b = bits[i];
            want[b] <= 1'b1;
            settle();
            chk_drv("main trip", ALL_ON, MAIN_OFF);
            chk_reg("trip flag", STATUS_OFS, 32'h1 << b, 32'h1 << b);
            if (b <= 4) begin
                want[b] <= 1'b0;
                settle();
                chk_drv("overspeed held", ALL_ON, MAIN_OFF);
                chk_reg("overspeed latch", STATUS_OFS, 32'h1 << (17 - b), 32'h1 << (17 - b));
                if (b == 4) begin
                    start_pulse();
                end else begin
                    want.override_held <= 1'b1;
                    settle();
                    want.override_held <= 1'b0;
                end
            end else begin
                // Lockout or limit stays active; no motion is asked toward a limit
                want.override_held <= 1'b1;
                settle();
                chk_drv("override", ALL_ON, (b == 9) ? MAIN_OFF : ALL_ON);
                want.override_held <= 1'b0;
                want[b]            <= 1'b0;
            end
            settle();
            chk_drv("main cleared", ALL_ON, ALL_ON);
        end
        $display("Test main_drive done");
    endtask : t_main

    task automatic t_latch_pin();
        want.el_latch_pin <= 1'b1;
        settle();
        chk_drv("latch pin", ALL_ON, 12'hfbf);
        chk_reg("latch flag", STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
        want.override_held <= 1'b1;
        settle();
        chk_drv("latch pin override", ALL_ON, 12'hfbf);
        want.override_held <= 1'b0;
        want.el_latch_pin  <= 1'b0;
        settle();
        chk_drv("latch pin cleared", ALL_ON, ALL_ON);
        $display("Test latch_pin done");
    endtask : t_latch_pin

    //--------------------------------------------------------------------------
    // Run control
    //--------------------------------------------------------------------------
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_power_up();
        t_estop();
        t_stop();
        t_watchdog();
        t_main();
        t_latch_pin();
        end_of_test();
    end

    // Hang limit
    initial begin
        repeat (90000) @(posedge clk_sys);
        fail_count++;
        $display("Error run length expected finish seen overrun");
        end_of_test();
    end
endmodule : test_drive_safety_interlock
